/* inc/tdpr_regs.svh */
// constants of the dual-port block memory: array geometry and timing counts
// assumes it is included by bare name from the interface, the design modules and the bench
`ifndef TDPR_REGS_SVH
`define TDPR_REGS_SVH

// ----------------------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------------------
`define TDPR_WORDS 512
`define TDPR_WORD_W 36
`define TDPR_WADDR_W 9
`define TDPR_DATA_W 32
`define TDPR_PAR_W 4
`define TDPR_PAR_LSB 32
`define TDPR_ADDR_W 14
`define TDPR_LANE_W 5

// ----------------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------------
`define TDPR_OUT_INIT 36'h0_0000_0000
`define TDPR_OUT_SET_RESET_VALUE 36'h0_0000_0000
`define TDPR_SETTLE_CYCLES 2'h3

`endif

/* inc/tdpr_pkg.sv */
// types shared by the dual-port block memory modules
// assumes tdpr_regs.svh is on the include path
package tdpr_pkg;

   // port aspect ratio, named by port width
   typedef enum logic [2:0] {
      TDPR_W1 = 3'b000,
      TDPR_W2 = 3'b001,
      TDPR_W4 = 3'b010,
      TDPR_W9 = 3'b011,
      TDPR_W18 = 3'b100,
      TDPR_W36 = 3'b101
   } tdpr_width_t;

   // what a write edge does to the output register
   typedef enum logic [1:0] {
      TDPR_WRITE_THROUGH = 2'b00,
      TDPR_READ_BEFORE = 2'b01,
      TDPR_HOLD_OUTPUT = 2'b10
   } tdpr_wmode_t;

endpackage : tdpr_pkg

/* inc/tdpr_port_if.sv */
// one memory port as seen after pin synchronisation and polarity handling
// assumes the front end and the array core share clk
`timescale 1ns/1ns
`include "tdpr_regs.svh"

interface tdpr_port_if;
   logic fire; // one-cycle pulse: enabled active port edge
   logic write; // write enable, already in active-high sense
   logic set_reset; // set/reset, already in active-high sense
   logic [`TDPR_ADDR_W-1:0] addr; // port address as presented
   logic [`TDPR_DATA_W-1:0] wdata; // write data, low bits used
   logic [`TDPR_PAR_W-1:0] wpar; // write parity, low bits used

   modport front (output fire, output write, output set_reset, output addr, output wdata, output wpar);
   modport core (input fire, input write, input set_reset, input addr, input wdata, input wpar);
endinterface : tdpr_port_if

/* rtl/tdpr_front.sv */
// pin front end of one memory port: synchroniser, edge pick, polarity
// assumes port pins are asynchronous to clk and change well apart from edges
`timescale 1ns/1ns
`include "tdpr_regs.svh"

module tdpr_front #(
   parameter bit CLK_INV = 1'b0,
   parameter bit EN_INV = 1'b0,
   parameter bit WE_INV = 1'b0,
   parameter bit SSR_INV = 1'b0
) (
   input wire logic clk, // core clock
   input wire logic rst, // synchronous reset
   input wire logic pin_clk, // port clock pin
   input wire logic pin_en, // port enable pin
   input wire logic pin_we, // port write enable pin
   input wire logic pin_ssr, // port set/reset pin
   input wire logic [`TDPR_ADDR_W-1:0] pin_addr, // port address pins
   input wire logic [`TDPR_DATA_W-1:0] pin_wdata, // port write data pins
   input wire logic [`TDPR_PAR_W-1:0] pin_wpar, // port write parity pins
   tdpr_port_if.front side // towards the array core
);

   localparam int BW = 4 + `TDPR_ADDR_W + `TDPR_DATA_W + `TDPR_PAR_W;

   // ----------------------------------------------------------------------------
   // two-stage synchroniser on the whole pin bundle
   // ----------------------------------------------------------------------------
   // controls travel in step with the clock pin, so the bundle seen with the
   // edge is the one sampled in the same cycle as the high clock level
   logic [BW-1:0] pins;
   logic [BW-1:0] meta_reg;
   logic [BW-1:0] sync_reg;
   logic clk_prev_reg;
   logic [1:0] settle_reg;
   logic [1:0] settle_next;

   assign pins = {pin_clk, pin_wpar, pin_wdata, pin_addr, pin_ssr, pin_we, pin_en};

   always_ff @(posedge clk) begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
   end

   // edges count only once the settle count reaches 3 after reset and the pipeline holds real samples
   assign settle_next = (settle_reg == `TDPR_SETTLE_CYCLES) ? settle_reg : settle_reg + 2'h1;

   always_ff @(posedge clk) begin
      if (rst) begin
         clk_prev_reg <= 1'b0;
         settle_reg <= 2'h0;
      end else begin
         clk_prev_reg <= sync_reg[BW-1] ^ CLK_INV;
         settle_reg <= settle_next;
      end
   end

   // ----------------------------------------------------------------------------
   // active edge and control polarity
   // ----------------------------------------------------------------------------
   logic clk_now;
   logic edge_seen;
   logic en_active;

   assign clk_now = sync_reg[BW-1] ^ CLK_INV;
   assign edge_seen = clk_now & ~clk_prev_reg & (settle_reg == `TDPR_SETTLE_CYCLES);
   assign en_active = sync_reg[0] ^ EN_INV;

   assign side.fire = edge_seen & en_active;
   assign side.write = sync_reg[1] ^ WE_INV;
   assign side.set_reset = sync_reg[2] ^ SSR_INV;
   assign side.addr = sync_reg[3 +: `TDPR_ADDR_W];
   assign side.wdata = sync_reg[3 + `TDPR_ADDR_W +: `TDPR_DATA_W];
   assign side.wpar = sync_reg[3 + `TDPR_ADDR_W + `TDPR_DATA_W +: `TDPR_PAR_W];

endmodule : tdpr_front

/* rtl/tdpr_top.sv */
// true dual-port 18-Kbit block memory with two independent ports A and B
// assumes port pins come from user logic on their own clocks; clk is much
// faster than either port clock and rst stands for device configuration
`timescale 1ns/1ns
`include "tdpr_regs.svh"

module tdpr_top import tdpr_pkg::*; #(
   parameter tdpr_width_t PORT_A_WIDTH = TDPR_W36,
   parameter tdpr_width_t PORT_B_WIDTH = TDPR_W36,
   parameter tdpr_wmode_t PORT_A_MODE = TDPR_WRITE_THROUGH,
   parameter tdpr_wmode_t PORT_B_MODE = TDPR_WRITE_THROUGH,
   parameter bit PORT_A_CLK_INV = 1'b0,
   parameter bit PORT_A_EN_INV = 1'b0,
   parameter bit PORT_A_WE_INV = 1'b0,
   parameter bit PORT_A_SSR_INV = 1'b0,
   parameter bit PORT_B_CLK_INV = 1'b0,
   parameter bit PORT_B_EN_INV = 1'b0,
   parameter bit PORT_B_WE_INV = 1'b0,
   parameter bit PORT_B_SSR_INV = 1'b0,
   parameter logic [`TDPR_WORD_W-1:0] PORT_A_INIT = `TDPR_OUT_INIT,
   parameter logic [`TDPR_WORD_W-1:0] PORT_B_INIT = `TDPR_OUT_INIT,
   parameter logic [`TDPR_WORD_W-1:0] PORT_A_SET_RESET_VALUE = `TDPR_OUT_SET_RESET_VALUE,
   parameter logic [`TDPR_WORD_W-1:0] PORT_B_SET_RESET_VALUE = `TDPR_OUT_SET_RESET_VALUE,
   parameter logic [`TDPR_WORDS*`TDPR_WORD_W-1:0] ARRAY_INIT_CONTENTS = '0
) (
   input wire logic clk, // core clock, 50 MHz
   input wire logic rst, // synchronous reset, acts as configuration
   input wire logic port_a_clk, // port A clock pin
   input wire logic port_a_enable, // port A enable
   input wire logic port_a_write_enable, // port A write enable
   input wire logic port_a_sync_set_reset, // port A output set/reset
   input wire logic [`TDPR_ADDR_W-1:0] port_a_addr, // port A address, low bits used
   input wire logic [`TDPR_DATA_W-1:0] port_a_write_data_in, // port A write data
   input wire logic [`TDPR_PAR_W-1:0] port_a_parity_in, // port A write parity
   output logic [`TDPR_DATA_W-1:0] port_a_read_data, // port A output register data
   output logic [`TDPR_PAR_W-1:0] port_a_parity_out, // port A output register parity
   input wire logic port_b_clk, // port B clock pin
   input wire logic port_b_enable, // port B enable
   input wire logic port_b_write_enable, // port B write enable
   input wire logic port_b_sync_set_reset, // port B output set/reset
   input wire logic [`TDPR_ADDR_W-1:0] port_b_addr, // port B address, low bits used
   input wire logic [`TDPR_DATA_W-1:0] port_b_write_data_in, // port B write data
   input wire logic [`TDPR_PAR_W-1:0] port_b_parity_in, // port B write parity
   output logic [`TDPR_DATA_W-1:0] port_b_read_data, // port B output register data
   output logic [`TDPR_PAR_W-1:0] port_b_parity_out // port B output register parity
);

   // ----------------------------------------------------------------------------
   // address and lane decoding
   // ----------------------------------------------------------------------------
   // word address into the 512 x 36 array
   function automatic logic [`TDPR_WADDR_W-1:0] word_of(tdpr_width_t w, logic [`TDPR_ADDR_W-1:0] a);
      unique case (w)
         TDPR_W1: word_of = a[13:5];
         TDPR_W2: word_of = a[12:4];
         TDPR_W4: word_of = a[11:3];
         TDPR_W9: word_of = a[10:2];
         TDPR_W18: word_of = a[9:1];
         TDPR_W36: word_of = a[8:0];
      endcase
   endfunction : word_of

   // lane inside the word, taken from the low address bits
   function automatic logic [`TDPR_LANE_W-1:0] lane_of(tdpr_width_t w, logic [`TDPR_ADDR_W-1:0] a);
      unique case (w)
         TDPR_W1: lane_of = a[4:0];
         TDPR_W2: lane_of = {1'b0, a[3:0]};
         TDPR_W4: lane_of = {2'h0, a[2:0]};
         TDPR_W9: lane_of = {3'h0, a[1:0]};
         TDPR_W18: lane_of = {4'h0, a[0]};
         TDPR_W36: lane_of = 5'h00;
      endcase
   endfunction : lane_of

   // bit offset of a lane within the data part of the word
   function automatic logic [4:0] lane_shift(tdpr_width_t w, logic [`TDPR_LANE_W-1:0] l);
      unique case (w)
         TDPR_W1: lane_shift = l;
         TDPR_W2: lane_shift = {l[3:0], 1'b0};
         TDPR_W4: lane_shift = {l[2:0], 2'h0};
         TDPR_W9: lane_shift = {l[1:0], 3'h0};
         TDPR_W18: lane_shift = {l[0], 4'h0};
         TDPR_W36: lane_shift = 5'h00;
      endcase
   endfunction : lane_shift

   // bits of the word that one access touches; the 1, 2 and 4 bit widths never reach
   // the parity columns, so they see only the 16-Kbit data portion
   function automatic logic [`TDPR_WORD_W-1:0] lane_mask(tdpr_width_t w, logic [`TDPR_LANE_W-1:0] l);
      logic [4:0] sh;
      sh = lane_shift(w, l);
      unique case (w)
         TDPR_W1: lane_mask = {4'h0, 32'h0000_0001 << sh};
         TDPR_W2: lane_mask = {4'h0, 32'h0000_0003 << sh};
         TDPR_W4: lane_mask = {4'h0, 32'h0000_000f << sh};
         TDPR_W9: lane_mask = {4'h1 << l[1:0], 32'h0000_00ff << sh};
         TDPR_W18: lane_mask = {4'h3 << {l[0], 1'b0}, 32'h0000_ffff << sh};
         TDPR_W36: lane_mask = 36'hf_ffff_ffff;
      endcase
   endfunction : lane_mask

   // write value copied into every lane; the mask keeps the right one
   function automatic logic [`TDPR_WORD_W-1:0] lane_fill(tdpr_width_t w, logic [`TDPR_DATA_W-1:0] d,
                                                         logic [`TDPR_PAR_W-1:0] p);
      unique case (w)
         TDPR_W1: lane_fill = {4'h0, {32{d[0]}}};
         TDPR_W2: lane_fill = {4'h0, {16{d[1:0]}}};
         TDPR_W4: lane_fill = {4'h0, {8{d[3:0]}}};
         TDPR_W9: lane_fill = {{4{p[0]}}, {4{d[7:0]}}};
         TDPR_W18: lane_fill = {{2{p[1:0]}}, {2{d[15:0]}}};
         TDPR_W36: lane_fill = {p, d};
      endcase
   endfunction : lane_fill

   // one lane of a word, right aligned as {parity, data}; unused bits are zero
   function automatic logic [`TDPR_WORD_W-1:0] lane_pick(tdpr_width_t w, logic [`TDPR_LANE_W-1:0] l,
                                                         logic [`TDPR_WORD_W-1:0] word);
      logic [`TDPR_DATA_W-1:0] d_sh;
      d_sh = word[`TDPR_DATA_W-1:0] >> lane_shift(w, l);
      unique case (w)
         TDPR_W1: lane_pick = {35'h0, d_sh[0]};
         TDPR_W2: lane_pick = {34'h0, d_sh[1:0]};
         TDPR_W4: lane_pick = {32'h0, d_sh[3:0]};
         TDPR_W9: lane_pick = {3'h0, word[`TDPR_PAR_LSB + l[1:0]], 24'h0, d_sh[7:0]};
         TDPR_W18: lane_pick = {2'h0, word[`TDPR_PAR_LSB + 2 * l[0] +: 2], 16'h0, d_sh[15:0]};
         TDPR_W36: lane_pick = word;
      endcase
   endfunction : lane_pick

   // ----------------------------------------------------------------------------
   // pin gathering
   // ----------------------------------------------------------------------------
   logic pin_clk [2];
   logic pin_en [2];
   logic pin_we [2];
   logic pin_ssr [2];
   logic [`TDPR_ADDR_W-1:0] pin_addr [2];
   logic [`TDPR_DATA_W-1:0] pin_wdata [2];
   logic [`TDPR_PAR_W-1:0] pin_wpar [2];

   assign pin_clk[0] = port_a_clk;
   assign pin_en[0] = port_a_enable;
   assign pin_we[0] = port_a_write_enable;
   assign pin_ssr[0] = port_a_sync_set_reset;
   assign pin_addr[0] = port_a_addr;
   assign pin_wdata[0] = port_a_write_data_in;
   assign pin_wpar[0] = port_a_parity_in;
   assign pin_clk[1] = port_b_clk;
   assign pin_en[1] = port_b_enable;
   assign pin_we[1] = port_b_write_enable;
   assign pin_ssr[1] = port_b_sync_set_reset;
   assign pin_addr[1] = port_b_addr;
   assign pin_wdata[1] = port_b_write_data_in;
   assign pin_wpar[1] = port_b_parity_in;

   // ----------------------------------------------------------------------------
   // shared storage
   // ----------------------------------------------------------------------------
   // 512 words of 32 data and 4 parity bits: one array behind both ports
   logic [`TDPR_WORD_W-1:0] mem [`TDPR_WORDS];

   logic fire_w [2];
   logic write_w [2];
   logic [`TDPR_WADDR_W-1:0] word_w [2];
   logic [`TDPR_WORD_W-1:0] mask_w [2];
   logic [`TDPR_WORD_W-1:0] wval_w [2];
   logic [`TDPR_WORD_W-1:0] out_reg [2];

   // ----------------------------------------------------------------------------
   // per-port logic
   // ----------------------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_port
      localparam tdpr_width_t WIDTH = (g == 0) ? PORT_A_WIDTH : PORT_B_WIDTH;
      localparam tdpr_wmode_t MODE = (g == 0) ? PORT_A_MODE : PORT_B_MODE;
      localparam logic [`TDPR_WORD_W-1:0] INIT = (g == 0) ? PORT_A_INIT : PORT_B_INIT;
      localparam logic [`TDPR_WORD_W-1:0] SET_RESET_VALUE = (g == 0) ? PORT_A_SET_RESET_VALUE : PORT_B_SET_RESET_VALUE;

      tdpr_port_if side ();

      tdpr_front #(
         .CLK_INV((g == 0) ? PORT_A_CLK_INV : PORT_B_CLK_INV),
         .EN_INV((g == 0) ? PORT_A_EN_INV : PORT_B_EN_INV),
         .WE_INV((g == 0) ? PORT_A_WE_INV : PORT_B_WE_INV),
         .SSR_INV((g == 0) ? PORT_A_SSR_INV : PORT_B_SSR_INV)
      ) u_front (
         .clk(clk),
         .rst(rst),
         .pin_clk(pin_clk[g]),
         .pin_en(pin_en[g]),
         .pin_we(pin_we[g]),
         .pin_ssr(pin_ssr[g]),
         .pin_addr(pin_addr[g]),
         .pin_wdata(pin_wdata[g]),
         .pin_wpar(pin_wpar[g]),
         .side(side.front)
      );

      logic [`TDPR_LANE_W-1:0] lane;
      logic [`TDPR_WORD_W-1:0] old_word;
      logic [`TDPR_WORD_W-1:0] old_lane;
      logic [`TDPR_WORD_W-1:0] new_lane;
      logic [`TDPR_WORD_W-1:0] write_view;
      logic [`TDPR_WORD_W-1:0] out_next;

      assign fire_w[g] = side.fire;
      assign write_w[g] = side.write;
      assign word_w[g] = word_of(WIDTH, side.addr);
      assign lane = lane_of(WIDTH, side.addr);
      assign mask_w[g] = lane_mask(WIDTH, lane);
      assign wval_w[g] = lane_fill(WIDTH, side.wdata, side.wpar) & mask_w[g];
      assign old_word = mem[word_w[g]];
      assign old_lane = lane_pick(WIDTH, lane, old_word);
      assign new_lane = lane_pick(WIDTH, lane, wval_w[g]);

      // what the output register sees on a write edge
      assign write_view = (MODE == TDPR_WRITE_THROUGH) ? new_lane :
                          (MODE == TDPR_READ_BEFORE) ? old_lane :
                          out_reg[g];

      // set/reset wins over the read or write view; the write itself still lands
      assign out_next = !side.fire ? out_reg[g] :
                        side.set_reset ? SET_RESET_VALUE :
                        side.write ? write_view : old_lane;

      always_ff @(posedge clk) begin
         if (rst) begin
            out_reg[g] <= INIT;
         end else begin
            out_reg[g] <= out_next;
         end
      end
   end : g_port

   // ----------------------------------------------------------------------------
   // array write
   // ----------------------------------------------------------------------------
   // both ports write in one process; when they hit the same word in one
   // cycle port B's merge, built from the old word, wins and port A's write is lost, a case user logic must keep away from
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `TDPR_WORDS; i++) begin
            mem[i] <= ARRAY_INIT_CONTENTS[i * `TDPR_WORD_W +: `TDPR_WORD_W];
         end
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (fire_w[p] && write_w[p]) begin
               mem[word_w[p]] <= (mem[word_w[p]] & ~mask_w[p]) | wval_w[p];
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   assign port_a_read_data = out_reg[0][`TDPR_DATA_W-1:0];
   assign port_a_parity_out = out_reg[0][`TDPR_PAR_LSB +: `TDPR_PAR_W];
   assign port_b_read_data = out_reg[1][`TDPR_DATA_W-1:0];
   assign port_b_parity_out = out_reg[1][`TDPR_PAR_LSB +: `TDPR_PAR_W];

endmodule : tdpr_top

/* tb/tdpr_user_port.sv */
// user logic on one memory port: makes the port clock and drives the pins
// assumes clk is the core clock; pins move only on its falling edge
`timescale 1ns/1ns
`include "tdpr_regs.svh"
module tdpr_user_port (
   input wire logic clk, // core clock
   output logic pclk, // port clock, still between operations
   output logic en, // port enable, active high
   output logic we, // write enable, active high
   output logic sync_set_reset, // output set/reset, active high
   output logic [`TDPR_ADDR_W-1:0] addr, // address
   output logic [`TDPR_DATA_W-1:0] wd, // write data
   output logic [`TDPR_PAR_W-1:0] par // write parity, kept but never generated here
);
   initial begin
      {pclk, en, we, sync_set_reset, addr, wd, par} = '0;
   end
   // --------------------------------------------------------------------------
   // one port cycle; the bench never overlaps the two ports on one word
   // --------------------------------------------------------------------------
   task automatic op(input logic e, input logic w, input logic s, input logic [13:0] a, input logic [35:0] d);
      @(negedge clk);
      {en, we, sync_set_reset, addr, par, wd} = {e, w, s, a, d};
      repeat (3) @(negedge clk);
      pclk = 1'b1;
      repeat (3) @(negedge clk);
      pclk = 1'b0;
      repeat (3) @(negedge clk);
      // released address, data and parity lines must not keep showing the last value
      {addr, par, wd} = ~{addr, par, wd};
      en = 1'b0;
   endtask : op
endmodule : tdpr_user_port

/* tb/tdpr_chk.sv */
// port-level checks of the dual-port memory: timing of output updates
// assumes active-high controls and rising port clock edges
`timescale 1ns/1ns
`include "tdpr_regs.svh"
module tdpr_chk #(
   parameter logic [35:0] A_INIT = '0,
   parameter logic [35:0] B_INIT = '0,
   parameter logic [35:0] A_SET_RESET_VALUE = '0,
   parameter logic [35:0] B_SET_RESET_VALUE = '0
) (
   input wire logic clk, // core clock
   input wire logic rst, // configuration reset
   input wire logic port_a_clk, // port A clock
   input wire logic port_a_enable, // port A enable
   input wire logic port_a_write_enable, // port A write enable
   input wire logic port_a_sync_set_reset, // port A set/reset
   input wire logic [`TDPR_DATA_W-1:0] port_a_write_data_in, // port A data in
   input wire logic [`TDPR_PAR_W-1:0] port_a_parity_in, // port A parity in
   input wire logic [`TDPR_DATA_W-1:0] port_a_read_data, // port A data out
   input wire logic [`TDPR_PAR_W-1:0] port_a_parity_out, // port A parity out
   input wire logic port_b_clk, // port B clock
   input wire logic port_b_enable, // port B enable
   input wire logic port_b_sync_set_reset, // port B set/reset
   input wire logic [`TDPR_DATA_W-1:0] port_b_read_data, // port B data out
   input wire logic [`TDPR_PAR_W-1:0] port_b_parity_out // port B parity out
);
   logic a_q, b_q;
   logic [4:0] a_h, b_h;
   wire a_rise = port_a_clk & ~a_q;
   wire b_rise = port_b_clk & ~b_q;
   wire [35:0] a_out = {port_a_parity_out, port_a_read_data};
   wire [35:0] b_out = {port_b_parity_out, port_b_read_data};
   always_ff @(posedge clk) begin
      a_q <= port_a_clk;
      b_q <= port_b_clk;
   end
   // recent port edges; the pin synchroniser delays the answer a few cycles
   always_ff @(posedge clk) begin
      a_h <= rst ? 5'h00 : {a_h[3:0], a_rise};
      b_h <= rst ? 5'h00 : {b_h[3:0], b_rise};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_a_fire; a_rise && port_a_enable; endsequence
   sequence s_b_fire; b_rise && port_b_enable; endsequence
   property p_a_edge_only; $changed(a_out) |-> a_h != 5'h00; endproperty
   a_a_edge_only: assert property (p_a_edge_only) else $error("port A output moved without a port edge");
   property p_b_edge_only; $changed(b_out) |-> b_h != 5'h00; endproperty
   a_b_edge_only: assert property (p_b_edge_only) else $error("port B output moved without a port edge");
   property p_a_off; a_rise && !port_a_enable |=> $stable(a_out)[*5]; endproperty
   a_a_off: assert property (p_a_off) else $error("disabled port A output changed");
   property p_b_off; b_rise && !port_b_enable |=> $stable(b_out)[*5]; endproperty
   a_b_off: assert property (p_b_off) else $error("disabled port B output changed");
   property p_a_ssr; s_a_fire ##0 port_a_sync_set_reset |-> ##[2:5] a_out == A_SET_RESET_VALUE; endproperty
   a_a_ssr: assert property (p_a_ssr) else $error("port A set/reset value missing");
   property p_b_ssr; s_b_fire ##0 port_b_sync_set_reset |-> ##[2:5] b_out == B_SET_RESET_VALUE; endproperty
   a_b_ssr: assert property (p_b_ssr) else $error("port B set/reset value missing");
   property p_a_thru;
      s_a_fire ##0 (port_a_write_enable && !port_a_sync_set_reset)
         |-> ##[2:5] a_out == {port_a_parity_in, port_a_write_data_in};
   endproperty
   a_a_thru: assert property (p_a_thru) else $error("port A write data not passed to output");
   property p_a_init; $fell(rst) |-> a_out == A_INIT; endproperty
   a_a_init: assert property (p_a_init) else $error("port A initial output wrong");
   property p_b_init; $fell(rst) |-> b_out == B_INIT; endproperty
   a_b_init: assert property (p_b_init) else $error("port B initial output wrong");
   property p_b_narrow; port_b_read_data[31:8] == 24'h0 && port_b_parity_out[3:1] == 3'h0; endproperty
   a_b_narrow: assert property (p_b_narrow) else $error("port B unused output bits set");
endmodule : tdpr_chk
bind tdpr_top tdpr_chk #(.A_INIT(PORT_A_INIT), .B_INIT(PORT_B_INIT), .A_SET_RESET_VALUE(PORT_A_SET_RESET_VALUE),
   .B_SET_RESET_VALUE(PORT_B_SET_RESET_VALUE)) tdpr_chk_inst (.clk, .rst, .port_a_clk, .port_a_enable,
   .port_a_write_enable, .port_a_sync_set_reset, .port_a_write_data_in, .port_a_parity_in, .port_a_read_data,
   .port_a_parity_out, .port_b_clk, .port_b_enable, .port_b_sync_set_reset, .port_b_read_data,
   .port_b_parity_out);

/* tb/tb_top.sv */
// testbench: port A 36 wide write-through, port B 9 wide read-before-write
// assumes the user port models drive all pins and a shadow array predicts data
`timescale 1ns/1ns
`include "tdpr_regs.svh"
module tb_top import tdpr_pkg::*;;
   localparam logic [35:0] INIT_A = 36'h1_2345_6789;
   localparam logic [35:0] INIT_B = 36'h0_0000_005c;
   localparam logic [35:0] SRV_A = 36'he_dcba_9876;
   localparam logic [35:0] SRV_B = 36'h1_0000_00a5;
   localparam logic [35:0] FILL = 36'h9_0f0f_1234;
   logic clk, rst, a_pclk, a_en, a_we, a_ssr, b_pclk, b_en, b_we, b_ssr;
   logic [13:0] a_addr, b_addr;
   logic [31:0] a_wd, b_wd, a_rd, b_rd, rnd;
   logic [3:0] a_par, b_par, a_po, b_po;
   logic [35:0] mem [`TDPR_WORDS];
   logic [35:0] d, v, keep;
   logic [8:0] wa;
   logic [1:0] l;
   int failures = 0, n_tests = 0, cycles = 0;
   tdpr_user_port pa (.clk(clk), .pclk(a_pclk), .en(a_en), .we(a_we), .sync_set_reset(a_ssr), .addr(a_addr), .wd(a_wd),
      .par(a_par));
   tdpr_user_port pb (.clk(clk), .pclk(b_pclk), .en(b_en), .we(b_we), .sync_set_reset(b_ssr), .addr(b_addr), .wd(b_wd),
      .par(b_par));
   tdpr_top #(.PORT_A_WIDTH(TDPR_W36), .PORT_B_WIDTH(TDPR_W9), .PORT_A_MODE(TDPR_WRITE_THROUGH),
      .PORT_B_MODE(TDPR_READ_BEFORE), .PORT_A_INIT(INIT_A), .PORT_B_INIT(INIT_B), .PORT_A_SET_RESET_VALUE(SRV_A),
      .PORT_B_SET_RESET_VALUE(SRV_B), .ARRAY_INIT_CONTENTS({`TDPR_WORDS{FILL}})) tdpr_top_inst (
      .clk(clk), .rst(rst), .port_a_clk(a_pclk), .port_a_enable(a_en), .port_a_write_enable(a_we),
      .port_a_sync_set_reset(a_ssr), .port_a_addr(a_addr), .port_a_write_data_in(a_wd), .port_a_parity_in(a_par),
      .port_a_read_data(a_rd), .port_a_parity_out(a_po), .port_b_clk(b_pclk), .port_b_enable(b_en),
      .port_b_write_enable(b_we), .port_b_sync_set_reset(b_ssr), .port_b_addr(b_addr),
      .port_b_write_data_in(b_wd), .port_b_parity_in(b_par), .port_b_read_data(b_rd), .port_b_parity_out(b_po));
   // ---------------------------------------------------------------------------
   // expectation helpers
   // ---------------------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // a 9-bit lane as port B shows it, right aligned
   function automatic logic [35:0] lane9(input logic [35:0] w, input logic [1:0] n);
      return {3'h0, w[32+n], 24'h0, w[8*n+:8]};
   endfunction : lane9
   function automatic logic [35:0] merge9(input logic [35:0] w, input logic [1:0] n, input logic [35:0] x);
      w[8*n+:8] = x[7:0];
      w[32+n] = x[32];
      return w;
   endfunction : merge9
   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   // ---------------------------------------------------------------------------
   // clock, hang guard and main sequence
   // ---------------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      rst = 1'b1;
      rnd = 32'h79bf6486;
      for (int i = 0; i < `TDPR_WORDS; i++) mem[i] = FILL;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      check("init a", {a_po, a_rd}, INIT_A);
      check("init b", {b_po, b_rd}, INIT_B);
      pa.op(1'b1, 1'b0, 1'b0, 14'h0005, 36'h0);
      check("fill a", {a_po, a_rd}, FILL);
      for (int n = 0; n < 24; n++) begin
         rnd = xs(rnd);
         d[31:0] = (n == 1) ? 32'hffff_ffff : rnd;
         rnd = xs(rnd);
         d[35:32] = (n == 1) ? 4'hf : rnd[15:12];
         wa = (n == 0) ? 9'h000 : (n == 1) ? 9'h1ff : rnd[8:0];
         l = (n == 0) ? 2'h0 : (n == 1) ? 2'h3 : rnd[10:9];
         v = {rnd[3:0], xs(rnd)};
         pa.op(1'b1, 1'b1, 1'b0, {rnd[20:16], wa}, d);
         mem[wa] = d;
         check("write a", {a_po, a_rd}, d);
         pb.op(1'b1, 1'b0, 1'b0, {3'h0, wa, l}, ~v);
         check("read b", {b_po, b_rd}, lane9(mem[wa], l));
         pb.op(1'b1, 1'b1, 1'b0, {3'h0, wa, l}, v);
         check("rbw b", {b_po, b_rd}, lane9(mem[wa], l));
         mem[wa] = merge9(mem[wa], l, v);
         pa.op(1'b1, 1'b0, 1'b0, {5'h0, wa}, ~d);
         check("read a", {a_po, a_rd}, mem[wa]);
      end
      keep = {a_po, a_rd};
      pa.op(1'b0, 1'b1, 1'b1, 14'h0000, ~mem[0]);
      check("off a", {a_po, a_rd}, keep);
      keep = {b_po, b_rd};
      pb.op(1'b0, 1'b1, 1'b1, 14'h0000, 36'h0);
      check("off b", {b_po, b_rd}, keep);
      pa.op(1'b1, 1'b0, 1'b0, 14'h0000, 36'h0);
      check("kept a", {a_po, a_rd}, mem[0]);
      pa.op(1'b1, 1'b0, 1'b1, 14'h0003, 36'h0);
      check("ssr a", {a_po, a_rd}, SRV_A);
      pb.op(1'b1, 1'b1, 1'b1, 14'h0001, 36'h1_0000_003c);
      check("ssr b", {b_po, b_rd}, SRV_B);
      pb.op(1'b1, 1'b0, 1'b0, 14'h0001, 36'h0);
      check("ssr store b", {b_po, b_rd}, 36'h1_0000_003c);
      tally_and_finish();
   end
endmodule : tb_top
